// ==== inc/ccp_pkg.sv ====
// shared constants and types of the capture/compare/pwm unit
package ccp_pkg;

  // register byte addresses on the plain register port
  localparam logic [7:0] ADDR_CONTROL     = 8'h00;
  localparam logic [7:0] ADDR_VALUE_LOW   = 8'h04;
  localparam logic [7:0] ADDR_VALUE_HIGH  = 8'h08;
  localparam logic [7:0] ADDR_FLAG        = 8'h0C;
  localparam logic [7:0] ADDR_FLAG_CLEAR  = 8'h10;
  localparam logic [7:0] ADDR_ENABLE      = 8'h14;
  localparam logic [7:0] ADDR_STATE       = 8'h18;

  // field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_DUTY_LSB  = 4;
  localparam int FLAG_CAPTURE   = 2;
  localparam int STATE_OUT_BIT  = 4;

  // reset values
  localparam logic [5:0]  CONTROL_RESET = 6'h00;
  localparam logic [15:0] VALUE_RESET   = 16'h0000;
  localparam logic [3:0]  PRESC_RESET   = 4'h0;

  // prescaler terminal counts (count of qualifying rising edges minus one)
  localparam logic [3:0] PRESC_DIV4_LAST  = 4'h3;
  localparam logic [3:0] PRESC_DIV16_LAST = 4'hF;

  // mode select field codes
  typedef enum logic [3:0] {
    MODE_OFF        = 4'b0000,
    MODE_CAP_FALL   = 4'b0100,
    MODE_CAP_RISE   = 4'b0101,
    MODE_CAP_RISE4  = 4'b0110,
    MODE_CAP_RISE16 = 4'b0111,
    MODE_CMP_SET    = 4'b1000,
    MODE_CMP_CLEAR  = 4'b1001,
    MODE_CMP_SOFT   = 4'b1010,
    MODE_CMP_TRIG   = 4'b1011
  } mode_e;

  // control register image: duty lsbs over mode select
  typedef struct packed {
    logic [1:0] dutyLsb;
    logic [3:0] modeSelect;
  } control_s;

  // one request on the register port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

  // true for the four capture codes 01xx
  function automatic logic isCaptureMode(input logic [3:0] m);
    return m[3:2] == 2'b01;
  endfunction

  // true for the four compare codes 10xx
  function automatic logic isCompareMode(input logic [3:0] m);
    return m[3:2] == 2'b10;
  endfunction

endpackage

// ==== rtl/ccp_edge_prescaler.sv ====
// capture pin synchroniser, edge detector and edge prescaler
`timescale 1ns/100ps
module ccp_edge_prescaler
  import ccp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       pinLevel,
  input  wire logic [3:0] modeSelect,
  input  wire logic       prescClear,
  output logic            captureEvent,
  output logic [3:0]      prescCount
);

  logic syncFirst;
  logic syncSecond;
  logic pinPrev;

  // two-flop synchroniser, then one more flop for edge history
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      syncFirst  <= 1'b0;
      syncSecond <= 1'b0;
      pinPrev    <= 1'b0;
    end
    else
    begin
      syncFirst  <= pinLevel;
      syncSecond <= syncFirst;
      pinPrev    <= syncSecond;
    end
  end

  // edges are taken only from the settled samples
  wire riseEdge = syncSecond & ~pinPrev;
  wire fallEdge = ~syncSecond & pinPrev;
  wire isCap    = isCaptureMode(modeSelect);

  // last count before an event for the divided settings
  wire [3:0] lastCount = (modeSelect == MODE_CAP_RISE16) ? PRESC_DIV16_LAST
                       : (modeSelect == MODE_CAP_RISE4)  ? PRESC_DIV4_LAST
                       : PRESC_RESET;
  wire       divided   = (modeSelect == MODE_CAP_RISE4) | (modeSelect == MODE_CAP_RISE16);
  // counter may hold a larger count after a 16 to 4 switch; >= still fires
  wire       divFire   = divided & riseEdge & (prescCount >= lastCount);
  wire       hit       = isCap & ((modeSelect == MODE_CAP_FALL) ? fallEdge
                       : (modeSelect == MODE_CAP_RISE) ? riseEdge
                       : divFire);

  wire [3:0] next_prescCount = (prescClear | ~isCap) ? PRESC_RESET
                             : divFire ? PRESC_RESET
                             : (divided & riseEdge) ? 4'(prescCount + 4'h1)
                             : prescCount;

  // one pulse per selected event, count kept across prescaler switches
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      prescCount   <= PRESC_RESET;
      captureEvent <= 1'b0;
    end
    else
    begin
      prescCount   <= next_prescCount;
      captureEvent <= hit;
    end
  end

endmodule

// ==== rtl/capture_compare_mode_control.sv ====
// capture/compare/pwm unit: control register, capture, compare and interrupt
//
// Behaviour
// - capture event copies 16-bit timer value
// - event: falling, rising, 4th or 16th rise
// - capture sets flag bit 2; software clears
// - new capture overwrites unread old value
// - port write on output pin can capture
// - mode change may raise spurious flag
// - prescaler cleared when off or not capturing
// - prescaler switch keeps count, may flag
// - mode zero disables and resets unit
// - code 1000 drives output high, flags
// - software-interrupt compare only sets flag
// - special event resets timer, starts conversion
// - codes 11xx pwm; bits 5:4 duty lsbs; no pwm is made here, 11xx holds the latch and leaves the pin undriven
// - top two bits read zero, rest reset zero
// - compare register continuously matched against timer
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module capture_compare_mode_control
  import ccp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire bus_req_s    busReq,
  output logic [7:0]       rdata,
  input  wire logic [15:0] timerCount,
  input  wire logic        capturePinIn,
  input  wire logic [1:0]  portDirection,
  input  wire logic [1:0]  portLatch,
  input  wire logic        pinLocationConfig,
  output logic             compareOut,
  output logic             compareDrive,
  output logic             timerReset,
  output logic             adcStart,
  output logic             irq
);

  control_s    control;
  logic [15:0] captureValue;
  logic        flagCapture;
  logic        enableCapture;
  logic        matchPrev;
  logic        captureEvent;
  logic [3:0]  prescCount;

  // register port decode
  // the port never stalls, so each strobe acts on the edge that sees it

  // address decode of the plain register port
  wire selControl  = busReq.addr == ADDR_CONTROL;
  wire selLow      = busReq.addr == ADDR_VALUE_LOW;
  wire selHigh     = busReq.addr == ADDR_VALUE_HIGH;
  wire selFlag     = busReq.addr == ADDR_FLAG;
  wire selFlagClr  = busReq.addr == ADDR_FLAG_CLEAR;
  wire selEnable   = busReq.addr == ADDR_ENABLE;
  wire selState    = busReq.addr == ADDR_STATE;

  // write strobes per register
  wire wrControl   = busReq.wr & selControl;
  wire wrLow       = busReq.wr & selLow;
  wire wrHigh      = busReq.wr & selHigh;
  wire wrFlagClr   = busReq.wr & selFlagClr;
  wire wrEnable    = busReq.wr & selEnable;

  // write data seen as a control image; bits 7:6 are dropped on purpose
  control_s writeControl;
  assign writeControl = control_s'(busReq.wdata[5:0]);

  // mode decode
  // codes 0001..0011 act as off for capture and compare but keep the latch

  // mode classes from the stored select field
  wire [3:0] mode      = control.modeSelect;
  wire       modeOff   = mode == MODE_OFF;
  wire       modeCap   = isCaptureMode(mode);
  wire       modeCmp   = isCompareMode(mode);
  wire       modePwm   = mode[3:2] == 2'b11;

  // mode classes of the incoming write
  wire       newCap    = isCaptureMode(writeControl.modeSelect);
  wire       newCmp    = isCompareMode(writeControl.modeSelect);

  // a direct switch between two capture settings leaves the counter
  // alone and the edge logic may see it as an event; raise the flag
  // so software that follows the off-then-on sequence sees no surprise
  wire captureSwitch = wrControl & modeCap & newCap
                     & (writeControl.modeSelect != mode);

  // prescaler is cleared when the unit is off or leaves capture
  wire prescClear = wrControl & ~newCap;

  // capture pin path
  // the pin mux sits ahead of the synchroniser, so a source switch is a plain edge

  // the pin lives on one of two port bits, chosen by configuration
  wire dirIsInput = pinLocationConfig ? portDirection[1] : portDirection[0];
  wire latchLevel = pinLocationConfig ? portLatch[1] : portLatch[0];

  // an output pin shows the port latch, so a latch write is an edge
  wire pinLevel = dirIsInput ? capturePinIn : latchLevel;
  // capture relies on software setting the direction bit to input;
  // when it is left as output the latch level above is what is captured

  ccp_edge_prescaler u_edge
  (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .pinLevel     (pinLevel),
    .modeSelect   (mode),
    .prescClear   (prescClear),
    .captureEvent (captureEvent),
    .prescCount   (prescCount)
  );

  // a pulse from the prescaler only counts while still capturing
  wire doCapture = captureEvent & modeCap;

  // compare path
  // the compare value shares its storage with the capture value

  // timer is taken as synchronous to sys_clk; an asynchronously
  // counting timer can give torn values here, which the user avoids
  wire matchNow  = timerCount == captureValue;
  // only the first cycle of a match acts, so a stopped timer sitting
  // on the compare value does not keep re-firing the flag
  wire matchHit  = modeCmp & matchNow & ~matchPrev;

  wire hitSet    = matchHit & (mode == MODE_CMP_SET);
  wire hitClear  = matchHit & (mode == MODE_CMP_CLEAR);
  wire hitTrig   = matchHit & (mode == MODE_CMP_TRIG);
  // software-interrupt compare touches nothing but the flag
  wire hitSoft   = matchHit & (mode == MODE_CMP_SOFT);

  // compare output latch: forced low when unit is off, held in pwm
  wire next_compareOut = modeOff  ? 1'b0
                       : hitSet   ? 1'b1
                       : hitClear ? 1'b0
                       : compareOut;

  // pin is driven only in set/clear compare modes; pwm timing lives
  // in the timer-2 block and is not produced here
  wire next_compareDrive = (mode == MODE_CMP_SET) | (mode == MODE_CMP_CLEAR);

  // capture/compare value register
  // one 16-bit store serves capture, compare and the duty byte

  // capture always wins over a software write in the same cycle
  wire [15:0] next_captureValue =
      doCapture ? timerCount
    : wrHigh    ? {busReq.wdata, captureValue[7:0]}
    : wrLow     ? {captureValue[15:8], busReq.wdata}
    : captureValue;

  // interrupt flag
  // capture and every compare action share this single bit

  // every source of the single flag bit
  wire flagEvent = doCapture | hitSet | hitClear | hitSoft | hitTrig | captureSwitch;
  wire flagClear = wrFlagClr & busReq.wdata[FLAG_CAPTURE];

  // set beats clear so an event in the clearing cycle is kept;
  // hardware itself never clears the flag
  wire next_flagCapture = flagEvent | (flagCapture & ~flagClear);

  // read mux
  // reads have no side effects, so polling the flag never loses an event

  // unmapped addresses and write-only clear register read zero
  wire [7:0] readMux =
      selControl ? {2'b00, control}
    : selLow     ? captureValue[7:0]
    : selHigh    ? captureValue[15:8]
    : selFlag    ? 8'(32'(flagCapture) << FLAG_CAPTURE)
    : selEnable  ? 8'(32'(enableCapture) << FLAG_CAPTURE)
    : selState   ? {3'b000, compareOut, prescCount}
    : 8'h00;

  // registers
  // all state resets synchronously and runs on every edge

  // control register: six bits, all reset to zero
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      control <= control_s'(CONTROL_RESET);
    else if (wrControl)
      control <= writeControl;
  end

  // capture/compare value
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      captureValue <= VALUE_RESET;
    else
      captureValue <= next_captureValue;
  end

  // flag and enable
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      flagCapture   <= 1'b0;
      enableCapture <= 1'b0;
    end
    else
    begin
      flagCapture   <= next_flagCapture;
      if (wrEnable)
        enableCapture <= busReq.wdata[FLAG_CAPTURE];
    end
  end

  // match history, cleared with the unit so a re-enabled compare
  // already sitting on a match fires once
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      matchPrev <= 1'b0;
    else
      matchPrev <= modeCmp & matchNow & ~(wrControl & ~newCmp);
  end

  // pin outputs of the compare path
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      compareOut   <= 1'b0;
      compareDrive <= 1'b0;
    end
    else
    begin
      compareOut   <= next_compareOut;
      compareDrive <= next_compareDrive;
    end
  end

  // special event trigger: one-cycle pulses to timer and converter
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      timerReset <= 1'b0;
      adcStart   <= 1'b0;
    end
    else
    begin
      timerReset <= hitTrig;
      adcStart   <= hitTrig;
    end
  end

  // interrupt level and read data, both registered outputs
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      irq   <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      // a software change of mode can raise the flag; keeping the
      // enable clear across the change hides it from irq
      irq   <= next_flagCapture & enableCapture;
      rdata <= busReq.rd ? readMux : 8'h00;
    end
  end

endmodule

// ==== tb/ccp_pin_source.sv ====
// capture pin source: idles low, gives one high pulse of a requested width
`timescale 1ns/100ps
module ccp_pin_source
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       pulseReq,
  input  wire logic [2:0] widthReq,
  output logic            pinLevel
);
  logic [2:0] left;

  // whole-cycle levels, so two edges never come closer than one cycle
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      left     <= 3'h0;
      pinLevel <= 1'b0;
    end
    else if (pulseReq)
    begin
      left     <= widthReq;
      pinLevel <= 1'b1;
    end
    else if (left > 3'h1)
      left <= left - 3'h1;
    else
    begin
      left     <= 3'h0;
      pinLevel <= 1'b0;
    end
  end
endmodule

// ==== tb/ccp_assertions.sv ====
// port checker for the capture/compare/pwm unit
`timescale 1ns/100ps
module ccp_assertions
  import ccp_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire bus_req_s    busReq,
  input wire logic [7:0]  rdata,
  input wire logic [15:0] timerCount,
  input wire logic        compareOut,
  input wire logic        compareDrive,
  input wire logic        timerReset,
  input wire logic        adcStart,
  input wire logic        irq
);
  logic [5:0]  ctrl;
  logic [15:0] val;
  wire  logic  ctrlWr = busReq.wr && busReq.addr == ADDR_CONTROL;
  wire  logic  ctrlRd = busReq.rd && busReq.addr == ADDR_CONTROL;
  wire  logic  clrRd  = busReq.rd && busReq.addr == ADDR_FLAG_CLEAR;
  wire  logic  enWr   = busReq.wr && busReq.addr == ADDR_ENABLE;

  // write shadows; captures are not mirrored, so val only serves compare checks
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ctrl <= CONTROL_RESET;
      val  <= VALUE_RESET;
    end
    else
    begin
      if (ctrlWr)
        ctrl <= busReq.wdata[5:0];
      if (busReq.wr && busReq.addr == ADDR_VALUE_LOW)
        val[7:0] <= busReq.wdata;
      if (busReq.wr && busReq.addr == ADDR_VALUE_HIGH)
        val[15:8] <= busReq.wdata;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // read data stand only in the cycle after a read
  idle_read_a:
    assert property (!$past(busReq.rd) |-> rdata == 8'h00) else $error("stray rdata");
  ctrl_read_a:
    assert property (ctrlRd |=> rdata == {2'b00, $past(ctrl)}) else $error("control readback");
  clr_read_a:
    assert property (clrRd |=> rdata == 8'h00) else $error("clear reg read");
  trig_mode_a:
    assert property (timerReset |-> adcStart && $past(ctrl[3:0]) == MODE_CMP_TRIG)
      else $error("trigger outside mode");
  trig_once_a:
    assert property (timerReset |=> !timerReset) else $error("long trigger");
  match_value_a:
    assert property (timerReset |-> $past(timerCount) == val) else $error("trigger off match");
  drive_mode_a:
    assert property (compareDrive |-> ctrl[3:1] == 3'b100 || $past(ctrl[3:1]) == 3'b100)
      else $error("drive outside mode");
  off_low_a:
    assert property (ctrlWr && busReq.wdata[3:0] == 4'h0 |-> ##[1:2] !(compareOut || compareDrive))
      else $error("off keeps output");
  irq_mask_a:
    assert property (enWr && !busReq.wdata[FLAG_CAPTURE] |-> ##[1:2] !irq) else $error("masked irq");
endmodule

bind capture_compare_mode_control ccp_assertions chk_u (
  .sys_clk(sys_clk), .srst(srst), .busReq(busReq), .rdata(rdata),
  .timerCount(timerCount), .compareOut(compareOut), .compareDrive(compareDrive),
  .timerReset(timerReset), .adcStart(adcStart), .irq(irq)
);

// ==== tb/capture_compare_mode_control_bench.sv ====
// self-checking bench for the capture/compare/pwm unit
`timescale 1ns/100ps
module capture_compare_mode_control_bench
  import ccp_pkg::*;
;
  logic        sys_clk           = 1'b0;
  logic        srst              = 1'b1;
  bus_req_s    busReq            = '0;
  logic [15:0] timerCount        = 16'h0000;
  logic [1:0]  portDirection     = 2'b11;
  logic [1:0]  portLatch         = 2'b00;
  logic        pinLocationConfig = 1'b0;
  logic        pulseReq          = 1'b0;
  logic [2:0]  widthReq          = 3'h1;
  logic [7:0]  rdata;
  logic        capturePin;
  logic        compareOut;
  logic        compareDrive;
  logic        timerReset;
  logic        adcStart;
  logic        irq;
  logic [15:0] t;
  logic        expOut;
  int          mismatches        = 0;
  int          samplesChecked    = 0;
  mode_e       capModes [4]      = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16};
  mode_e       cmpModes [5]      = '{MODE_CMP_TRIG, MODE_CMP_SET, MODE_CMP_CLEAR, MODE_CMP_SET,
                                     MODE_CMP_SOFT};

  always #12.5 sys_clk = ~sys_clk;

  capture_compare_mode_control dut_u (
    .sys_clk(sys_clk), .srst(srst), .busReq(busReq), .rdata(rdata), .timerCount(timerCount),
    .capturePinIn(capturePin), .portDirection(portDirection), .portLatch(portLatch),
    .pinLocationConfig(pinLocationConfig), .compareOut(compareOut),
    .compareDrive(compareDrive), .timerReset(timerReset), .adcStart(adcStart), .irq(irq));

  ccp_pin_source pin_u (
    .sys_clk(sys_clk), .srst(srst), .pulseReq(pulseReq), .widthReq(widthReq),
    .pinLevel(capturePin));

  // pulses needed per capture code
  function automatic int edgesFor(input mode_e m);
    return (m == MODE_CAP_RISE4) ? 4 : (m == MODE_CAP_RISE16) ? 16 : 1;
  endfunction

  // output latch after a match: set and clear act, the others leave it alone
  function automatic logic nextOut(input mode_e m, input logic prev);
    return (m == MODE_CMP_SET) ? 1'b1 : (m == MODE_CMP_CLEAR) ? 1'b0 : prev;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    busReq.wr <= 1'b0;
  endtask

  // read data are looked at in the single cycle they stand
  task automatic chkReg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    busReq.rd <= 1'b0;
    #1 check(rdata, exp);
    // back onto the rising edge so the caller's next drive lands there
    @(posedge sys_clk);
  endtask

  // 14 cycles cover the widest pulse plus the four-edge capture path
  task automatic pulse();
    @(posedge sys_clk);
    widthReq <= 3'($urandom_range(6, 1));
    pulseReq <= 1'b1;
    @(posedge sys_clk);
    pulseReq <= 1'b0;
    repeat (14) @(posedge sys_clk);
  endtask

  task automatic testDone();
    if (mismatches == 0 && samplesChecked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // watchdog: the whole sequence needs about 650 cycles, 4000 leaves margin
  initial
  begin
    repeat (4000) @(posedge sys_clk);
    mismatches++;
    testDone();
  end

  initial
  begin
    void'($urandom(32'h2916720e));
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    chkReg(ADDR_CONTROL, 8'h00);
    chkReg(ADDR_VALUE_LOW, 8'h00);
    chkReg(ADDR_FLAG, 8'h00);
    wrReg(ADDR_CONTROL, 8'hFF);
    chkReg(ADDR_CONTROL, 8'h3F);
    wrReg(8'h1C, 8'hFF);
    chkReg(8'h1C, 8'h00);
    chkReg(ADDR_FLAG_CLEAR, 8'h00);
    wrReg(ADDR_ENABLE, 8'h04);
    // every capture code: n-1 edges leave the flag clear, the nth captures
    foreach (capModes[i])
    begin
      wrReg(ADDR_CONTROL, 8'h00);
      wrReg(ADDR_FLAG_CLEAR, 8'h04);
      wrReg(ADDR_CONTROL, {4'h0, capModes[i]});
      repeat (edgesFor(capModes[i]) - 1) pulse();
      chkReg(ADDR_FLAG, 8'h00);
      t = 16'($urandom);
      timerCount <= t;
      pulse();
      check(irq, 1'b1);
      chkReg(ADDR_FLAG, 8'h04);
      chkReg(ADDR_VALUE_LOW, t[7:0]);
      chkReg(ADDR_VALUE_HIGH, t[15:8]);
    end
    // port-latch edges on an output pin at the other location; unread value is overwritten
    pinLocationConfig <= 1'b1;
    portDirection <= 2'b01;
    wrReg(ADDR_CONTROL, {4'h0, MODE_CAP_RISE});
    repeat (2)
    begin
      t = 16'($urandom);
      timerCount <= t;
      portLatch <= 2'b10;
      repeat (6) @(posedge sys_clk);
      portLatch <= 2'b00;
      repeat (6) @(posedge sys_clk);
    end
    chkReg(ADDR_VALUE_LOW, t[7:0]);
    chkReg(ADDR_VALUE_HIGH, t[15:8]);
    // a direct prescaler switch keeps the count and flags; turning off clears it
    pinLocationConfig <= 1'b0;
    portDirection <= 2'b11;
    wrReg(ADDR_CONTROL, 8'h00);
    wrReg(ADDR_FLAG_CLEAR, 8'h04);
    wrReg(ADDR_CONTROL, {4'h0, MODE_CAP_RISE16});
    repeat (3) pulse();
    chkReg(ADDR_STATE, 8'h03);
    wrReg(ADDR_CONTROL, {4'h0, MODE_CAP_RISE4});
    chkReg(ADDR_FLAG, 8'h04);
    wrReg(ADDR_FLAG_CLEAR, 8'h04);
    pulse();
    chkReg(ADDR_FLAG, 8'h04);
    wrReg(ADDR_ENABLE, 8'h00);
    wrReg(ADDR_CONTROL, 8'h00);
    chkReg(ADDR_STATE, 8'h00);
    check(irq, 1'b0);
    // compare codes in turn; the timer meets the compare value one cycle after the write
    expOut = 1'b0;
    foreach (cmpModes[i])
    begin
      t = 16'($urandom);
      timerCount <= ~t;
      if (cmpModes[i] == MODE_CMP_TRIG)
        wrReg(ADDR_CONTROL, 8'h00);
      wrReg(ADDR_FLAG_CLEAR, 8'h04);
      wrReg(ADDR_VALUE_LOW, t[7:0]);
      wrReg(ADDR_VALUE_HIGH, t[15:8]);
      wrReg(ADDR_CONTROL, {4'h0, cmpModes[i]});
      timerCount <= t;
      @(posedge sys_clk);
      #1 check(timerReset, cmpModes[i] == MODE_CMP_TRIG);
      check(adcStart, cmpModes[i] == MODE_CMP_TRIG);
      expOut = nextOut(cmpModes[i], expOut);
      @(posedge sys_clk);
      timerCount <= ~t;
      chkReg(ADDR_FLAG, 8'h04);
      check(compareOut, expOut);
      check(compareDrive, cmpModes[i] inside {MODE_CMP_SET, MODE_CMP_CLEAR});
    end
    wrReg(ADDR_CONTROL, 8'h00);
    chkReg(ADDR_STATE, 8'h00);
    check(compareOut, 1'b0);
    testDone();
  end
endmodule
